// ===== hdl/cpu_bus_command_controller.v
// Processor bus command and control generator
//
// Behaviour
// - Passive status keeps every command output high.
// - Address strobe is active high; latches capture at its falling edge.
// - Active-high transceiver enable during the data phase, except for I/O cycles in I/O bus mode.
// - Direction high for write cycles, low for read cycles.
// - Commands enabled 110 to 250 ns after grant goes low.
// - Grant inactive releases command drivers at once, unclocked.
// - In I/O bus mode the I/O commands ignore the grant.
// - Command enable low forces commands, transceiver and peripheral enables inactive.
// - Strap high selects I/O bus mode, low selects system bus mode.
// - Early I/O write asserts with read timing, before normal write.
// - I/O write command asserted low during I/O write cycles.
// - I/O read command asserted low during I/O read cycles.
// - All command and control outputs timed from the clock.
// - Status decode: ack, I/O read, I/O write, halt, memory read/write, passive.
// - Shared pin: cascade enable in system mode, peripheral enable low in I/O mode.
// - System bus mode holds memory and I/O commands until granted.
`timescale 1ns/1ps
`default_nettype none
`include "bus_cmd_regs.vh"

module cpu_bus_command_controller #(
    parameter GRANT_DELAY = `GRANT_MIN_CYC
) (
    // Clock and reset
    input  wire clk,
    input  wire sys_rst,
    // Processor status pins
    input  wire cpuStatusBit0,
    input  wire cpuStatusBit1,
    input  wire cpuStatusBit2,
    // Arbiter, enable and strap pins
    input  wire arbiterBusGrantN,
    input  wire cmdOutputEnable,
    input  wire busModeStrap,
    // Command outputs, active low
    output reg  irqAcknowledgeN,
    output reg  ioReadN,
    output reg  ioWriteN,
    output reg  earlyIoWriteN,
    output reg  memReadN,
    output reg  memWriteN,
    output reg  earlyMemWriteN,
    // Command driver enables, high while driving
    output wire ioCmdDriveEn,
    output wire memCmdDriveEn,
    // Control outputs
    output reg  addrLatchStrobe,
    output reg  xcvrEnable,
    output reg  xcvrDirection,
    output reg  cascadeOrPeriphEnable
);

    // ------------------------------------------------------------
    // Cycle phases
    // ------------------------------------------------------------
    localparam [1:0] PH_IDLE  = 2'h0;
    localparam [1:0] PH_ADDR  = 2'h1;
    localparam [1:0] PH_EARLY = 2'h2;
    localparam [1:0] PH_LATE  = 2'h3;

    localparam [`GRANT_CNT_W-1:0] GRANT_TARGET = GRANT_DELAY[`GRANT_CNT_W-1:0];

    // ------------------------------------------------------------
    // Status decode
    // ------------------------------------------------------------
    function [`KIND_W-1:0] decodeKind;
        input [2:0] status;
        begin
            decodeKind = `KIND_NONE;
            case (status)
                `ST_IRQ_ACK:   decodeKind[`KIND_IRQ_ACK]   = 1'b1;
                `ST_IO_READ:   decodeKind[`KIND_IO_READ]   = 1'b1;
                `ST_IO_WRITE:  decodeKind[`KIND_IO_WRITE]  = 1'b1;
                `ST_CODE_READ: decodeKind[`KIND_MEM_READ]  = 1'b1;
                `ST_MEM_READ:  decodeKind[`KIND_MEM_READ]  = 1'b1;
                `ST_MEM_WRITE: decodeKind[`KIND_MEM_WRITE] = 1'b1;
                default:       decodeKind = `KIND_NONE;
            endcase
        end
    endfunction

    function isIoKind;
        input [`KIND_W-1:0] kind;
        begin
            isIoKind = kind[`KIND_IRQ_ACK] | kind[`KIND_IO_READ] | kind[`KIND_IO_WRITE];
        end
    endfunction

    function isWriteKind;
        input [`KIND_W-1:0] kind;
        begin
            isWriteKind = kind[`KIND_IO_WRITE] | kind[`KIND_MEM_WRITE];
        end
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    reg  [2:0]              statusMeta;
    reg  [2:0]              statusSync;
    reg                     grantMeta;
    reg                     grantSyncN;
    reg                     cenMeta;
    reg                     cenSync;
    reg                     strapMeta;
    reg                     ioMode;

    always @(posedge clk) begin
        if (sys_rst) begin
            statusMeta <= `ST_PASSIVE;
            statusSync <= `ST_PASSIVE;
            grantMeta  <= 1'b1;
            grantSyncN <= 1'b1;
            cenMeta    <= 1'b0;
            cenSync    <= 1'b0;
            strapMeta  <= 1'b0;
            ioMode     <= 1'b0;
        end else begin
            statusMeta <= {cpuStatusBit2, cpuStatusBit1, cpuStatusBit0};
            statusSync <= statusMeta;
            grantMeta  <= arbiterBusGrantN;
            grantSyncN <= grantMeta;
            cenMeta    <= cmdOutputEnable;
            cenSync    <= cenMeta;
            strapMeta  <= busModeStrap;
            ioMode     <= strapMeta;
        end
    end

    // ------------------------------------------------------------
    // Grant delay counter
    // ------------------------------------------------------------
    reg  [`GRANT_CNT_W-1:0] grantCnt;
    wire                    grantReady;

    assign grantReady = (grantCnt == GRANT_TARGET);

    always @(posedge clk) begin
        if (sys_rst) begin
            grantCnt <= `GRANT_CNT_RST;
        end else if (grantSyncN) begin
            grantCnt <= `GRANT_CNT_RST;
        end else if (!grantReady) begin
            grantCnt <= grantCnt + {{(`GRANT_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    reg  [1:0]              phase;
    reg  [1:0]              next_phase;
    reg  [`KIND_W-1:0]      kind;
    reg  [`KIND_W-1:0]      next_kind;
    wire                    statusPassive;

    assign statusPassive = (statusSync == `ST_PASSIVE);

    // begin and end at passive code
    always @* begin
        next_phase = phase;
        next_kind  = kind;
        case (phase)
            PH_IDLE: begin
                if (!statusPassive) begin
                    next_phase = PH_ADDR;
                    next_kind  = decodeKind(statusSync);
                end
            end
            PH_ADDR: begin
                next_phase = statusPassive ? PH_IDLE : PH_EARLY;
            end
            PH_EARLY: begin
                next_phase = statusPassive ? PH_IDLE : PH_LATE;
            end
            PH_LATE: begin
                if (statusPassive) begin
                    next_phase = PH_IDLE;
                end
            end
            default: begin
                next_phase = PH_IDLE;
            end
        endcase
        if (next_phase == PH_IDLE) begin
            next_kind = `KIND_NONE;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            phase <= PH_IDLE;
            kind  <= `KIND_NONE;
        end else begin
            phase <= next_phase;
            kind  <= next_kind;
        end
    end

    // ------------------------------------------------------------
    // Command gating
    // ------------------------------------------------------------
    wire                    ioCmdAllowed;
    wire                    memCmdAllowed;
    wire                    earlyPhase;
    wire                    latePhase;

    assign ioCmdAllowed  = cenSync & (ioMode | grantReady);
    assign memCmdAllowed = cenSync & grantReady;

    assign earlyPhase = (next_phase == PH_EARLY) | (next_phase == PH_LATE);
    assign latePhase  = (next_phase == PH_LATE);

    // ------------------------------------------------------------
    // Next output values
    // ------------------------------------------------------------
    reg                     next_irqAcknowledgeN;
    reg                     next_ioReadN;
    reg                     next_ioWriteN;
    reg                     next_earlyIoWriteN;
    reg                     next_memReadN;
    reg                     next_memWriteN;
    reg                     next_earlyMemWriteN;
    reg                     next_addrLatchStrobe;
    reg                     next_xcvrEnable;
    reg                     next_xcvrDirection;
    reg                     next_cascadeOrPeriphEnable;
    reg                     dataPhase;

    always @*   begin
        dataPhase = earlyPhase & (next_kind != `KIND_NONE);
        // inactive high unless a cycle asks
        next_irqAcknowledgeN = 1'b1;
        next_ioReadN         = 1'b1;
        next_ioWriteN        = 1'b1;
        next_earlyIoWriteN   = 1'b1;
        next_memReadN        = 1'b1;
        next_memWriteN       = 1'b1;
        next_earlyMemWriteN  = 1'b1;
        if (earlyPhase && ioCmdAllowed) begin
            next_irqAcknowledgeN = ~next_kind[`KIND_IRQ_ACK];
            next_ioReadN         = ~next_kind[`KIND_IO_READ];
            // early I/O write with read timing
            next_earlyIoWriteN   = ~next_kind[`KIND_IO_WRITE];
        end
        if (latePhase && ioCmdAllowed) begin
            next_ioWriteN = ~next_kind[`KIND_IO_WRITE];
        end
        if (earlyPhase && memCmdAllowed) begin
            next_memReadN       = ~next_kind[`KIND_MEM_READ];
            next_earlyMemWriteN = ~next_kind[`KIND_MEM_WRITE];
        end
        if (latePhase && memCmdAllowed) begin
            next_memWriteN = ~next_kind[`KIND_MEM_WRITE];
        end

        // address strobe high in address phase
        next_addrLatchStrobe = (next_phase == PH_ADDR) && (statusSync != `ST_PASSIVE);

        next_xcvrDirection = (next_phase != PH_IDLE) && isWriteKind(next_kind);

        if (ioMode && isIoKind(next_kind)) begin
            next_xcvrEnable = 1'b0;
        end else begin
            next_xcvrEnable = dataPhase & cenSync;
        end

        if (ioMode) begin
            next_cascadeOrPeriphEnable = ~(dataPhase & cenSync & isIoKind(next_kind));
        end else begin
            next_cascadeOrPeriphEnable = (next_phase == PH_ADDR) &&
                                         next_kind[`KIND_IRQ_ACK];
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // outputs registered by the clock
    always @(posedge clk) begin
        if (sys_rst) begin
            irqAcknowledgeN       <= 1'b1;
            ioReadN               <= 1'b1;
            ioWriteN              <= 1'b1;
            earlyIoWriteN         <= 1'b1;
            memReadN              <= 1'b1;
            memWriteN             <= 1'b1;
            earlyMemWriteN        <= 1'b1;
            addrLatchStrobe       <= 1'b0;
            xcvrEnable            <= 1'b0;
            xcvrDirection         <= 1'b0;
            cascadeOrPeriphEnable <= 1'b0;
        end else begin
            irqAcknowledgeN       <= next_irqAcknowledgeN;
            ioReadN               <= next_ioReadN;
            ioWriteN              <= next_ioWriteN;
            earlyIoWriteN         <= next_earlyIoWriteN;
            memReadN              <= next_memReadN;
            memWriteN             <= next_memWriteN;
            earlyMemWriteN        <= next_earlyMemWriteN;
            addrLatchStrobe       <= next_addrLatchStrobe;
            xcvrEnable            <= next_xcvrEnable;
            xcvrDirection         <= next_xcvrDirection;
            cascadeOrPeriphEnable <= next_cascadeOrPeriphEnable;
        end
    end

    // ------------------------------------------------------------
    // Command driver enables
    // ------------------------------------------------------------
    // unclocked release when grant inactive
    // I/O group always driven in I/O mode
    assign ioCmdDriveEn  = ioMode | ~arbiterBusGrantN;
    assign memCmdDriveEn = ~arbiterBusGrantN;

endmodule // cpu_bus_command_controller

`default_nettype wire

// ===== hdl/bus_cmd_regs.vh
// Constants for the processor bus command controller
`ifndef BUS_CMD_REGS_VH
`define BUS_CMD_REGS_VH

// ----------------------------------------------------------------
// Status codes (bit2, bit1, bit0)
// ----------------------------------------------------------------
`define ST_IRQ_ACK      3'h0
`define ST_IO_READ      3'h1
`define ST_IO_WRITE     3'h2
`define ST_HALT         3'h3
`define ST_CODE_READ    3'h4
`define ST_MEM_READ     3'h5
`define ST_MEM_WRITE    3'h6
`define ST_PASSIVE      3'h7

// ----------------------------------------------------------------
// Cycle kind vector bit positions
// ----------------------------------------------------------------
`define KIND_W          5
`define KIND_IRQ_ACK    0
`define KIND_IO_READ    1
`define KIND_IO_WRITE   2
`define KIND_MEM_READ   3
`define KIND_MEM_WRITE  4
`define KIND_NONE       5'h00

// ----------------------------------------------------------------
// Grant to command timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   20
`define T_GRANT_MIN_NS  110
`define T_GRANT_MAX_NS  250
`define GRANT_MIN_CYC   ((`T_GRANT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GRANT_MAX_CYC   (`T_GRANT_MAX_NS / `CLK_PERIOD_NS)
`define SYNC_STAGES     2
`define GRANT_CNT_W     4
`define GRANT_CNT_RST   4'h0

`endif

// ===== bench/bus_cmd_sva.sv
// Assertion checker for the bus command controller
`timescale 1ns/1ps
`default_nettype none
module bus_cmd_sva (
    // Clock, reset and inputs
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cpuStatusBit0,
    input wire logic cpuStatusBit1,
    input wire logic cpuStatusBit2,
    input wire logic arbiterBusGrantN,
    input wire logic cmdOutputEnable,
    input wire logic busModeStrap,
    // Outputs
    input wire logic irqAcknowledgeN,
    input wire logic ioReadN,
    input wire logic ioWriteN,
    input wire logic earlyIoWriteN,
    input wire logic memReadN,
    input wire logic memWriteN,
    input wire logic earlyMemWriteN,
    input wire logic memCmdDriveEn,
    input wire logic addrLatchStrobe,
    input wire logic xcvrEnable,
    input wire logic xcvrDirection
);
    logic [3:0] gLow;
    logic [3:0] quiet;
    wire  [2:0] st    = {cpuStatusBit2, cpuStatusBit1, cpuStatusBit0};
    wire        allHi = &{irqAcknowledgeN, ioReadN, ioWriteN, earlyIoWriteN,
                          memReadN, memWriteN, earlyMemWriteN};
    // Strobe of a cycle whose gating has long been open
    wire        go    = addrLatchStrobe && quiet > 4'hb;

    // Grant age, and grant plus enable age, saturating
    always_ff @(posedge clk) begin
        if (sys_rst || arbiterBusGrantN) begin
            gLow <= 4'h0;
        end else if (gLow != 4'hf) begin
            gLow <= gLow + 4'h1;
        end
        if (sys_rst || arbiterBusGrantN || !cmdOutputEnable) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence early_then_late(e, l);
        !e && l ##1 !l;
    endsequence

    a_passive_idle: assert property ((st == 3'h7) [*4] |-> allHi)
        else $error("command active while status passive");
    a_strobe_single: assert property (addrLatchStrobe |=> !addrLatchStrobe)
        else $error("address strobe longer than one cycle");
    a_mem_read: assert property (go && st[2] && !st[1] |=>
        !memReadN && xcvrEnable && !xcvrDirection) else $error("memory read cycle wrong");
    a_mem_write: assert property (go && st == 3'h6 |->
        xcvrDirection ##1 early_then_late(earlyMemWriteN, memWriteN))
        else $error("memory write order wrong");
    a_io_write: assert property (go && st == 3'h2 |=>
        early_then_late(earlyIoWriteN, ioWriteN)) else $error("io write order wrong");
    a_io_read: assert property (go && st == 3'h1 |=>
        !ioReadN && xcvrEnable != busModeStrap) else $error("io read cycle wrong");
    a_halt_quiet: assert property (addrLatchStrobe && st == 3'h3 |=> allHi [*3])
        else $error("command during halt");
    a_grant_min: assert property ($fell(memReadN) |-> gLow > 4'h5)
        else $error("memory command too soon after grant");
    a_cen_force: assert property (!cmdOutputEnable [*4] |-> allHi && !xcvrEnable)
        else $error("outputs active while command enable low");
    a_grant_release: assert property (arbiterBusGrantN |-> !memCmdDriveEn)
        else $error("memory drivers enabled without grant");
endmodule // bus_cmd_sva

bind cpu_bus_command_controller bus_cmd_sva chk_u (.*);
`default_nettype wire

// ===== bench/cpu_status_model.sv
// Processor status and board command line model
`timescale 1ns/1ps
`default_nettype none
module cpu_status_model (
    // Clock and request
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [2:0] code,
    input  wire logic [5:0] len,
    // Status pins
    output var  logic       cpuStatusBit0,
    output var  logic       cpuStatusBit1,
    output var  logic       cpuStatusBit2,
    // Memory read line with pull-up
    input  wire logic       memReadN,
    input  wire logic       memCmdDriveEn,
    output wire logic       memReadLine
);
    logic [5:0] left = 6'h00;

    initial {cpuStatusBit2, cpuStatusBit1, cpuStatusBit0} = 3'h7;

    always @(posedge clk) begin
        if (go) begin
            {cpuStatusBit2, cpuStatusBit1, cpuStatusBit0} <= code;
            left <= len;
        end else if (left != 6'h00) begin
            left <= left - 6'h01;
            if (left == 6'h01) begin
                {cpuStatusBit2, cpuStatusBit1, cpuStatusBit0} <= 3'h7;
            end
        end
    end

    assign memReadLine = memCmdDriveEn ? memReadN : 1'b1;
endmodule // cpu_status_model
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the bus command controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk;
    logic        sys_rst          = 1'b1;
    logic        arbiterBusGrantN = 1'b0;
    logic        cmdOutputEnable  = 1'b1;
    logic        busModeStrap     = 1'b0;
    logic        go               = 1'b0;
    logic [2:0]  code             = 3'h7;
    logic [5:0]  len              = 6'h00;
    int          nFail            = 0;
    int          totalChecks      = 0;
    int          n;
    wire         cpuStatusBit0, cpuStatusBit1, cpuStatusBit2, memReadLine;
    wire         irqAcknowledgeN, ioReadN, ioWriteN, earlyIoWriteN;
    wire         memReadN, memWriteN, earlyMemWriteN, ioCmdDriveEn, memCmdDriveEn;
    wire         addrLatchStrobe, xcvrEnable, xcvrDirection, cascadeOrPeriphEnable;
    wire  [8:0]  seen = {irqAcknowledgeN, ioReadN, ioWriteN, earlyIoWriteN, memReadN,
                         memWriteN, earlyMemWriteN, xcvrEnable, xcvrDirection};
    // Status code beside expected commands, enable and direction
    logic [11:0] rows [0:7] = '{12'h0fe, 12'h37e, 12'h59f, 12'h7fc,
                                12'h9ee, 12'hbee, 12'hdf3, 12'hffc};

    cpu_bus_command_controller dut_u (.*);
    cpu_status_model cpu_u (.*);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic endSim();
        if (nFail == 0 && totalChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [8:0] e, input logic [8:0] g);
        totalChecks++;
        if (g !== e) begin
            nFail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic doReset();
        @(posedge clk);
        sys_rst <= 1'b1;
        ticks(16);
        sys_rst <= 1'b0;
        ticks(3);
        @(negedge clk);
    endtask

    task automatic cyc(input logic [2:0] c, input logic [5:0] l);
        @(posedge clk);
        code <= c;
        len  <= l;
        go   <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask

    task automatic run(input logic [2:0] c, input logic [8:0] e, input logic [1:0] e2,
                       input string nm);
        cyc(c, 6'h0a);
        ticks(3);
        @(negedge clk);
        check({nm, " strobe"}, {7'h00, c != 3'h7, busModeStrap || c == 3'h0},
              {7'h00, addrLatchStrobe, cascadeOrPeriphEnable});
        ticks(3);
        @(negedge clk);
        check(nm, e, seen);
        check(nm, {7'h00, e2}, {7'h00, ioCmdDriveEn, cascadeOrPeriphEnable});
        ticks(9);
        @(negedge clk);
        check("idle after cycle", 9'h1fc, seen);
    endtask

    initial begin
        ticks(2000);
        nFail++;
        endSim();
    end

    initial begin
        doReset();
        check("reset idle", 9'h1fc, seen);
        ticks(12);
        for (int i = 0; i < 8; i++) begin
            run(rows[i][11:9], rows[i][8:0], 2'h2, $sformatf("code %0d", i));
        end
        @(posedge clk);
        cmdOutputEnable <= 1'b0;
        run(3'h4, 9'h1fc, 2'h2, "command enable low");
        @(posedge clk);
        arbiterBusGrantN <= 1'b1;
        cmdOutputEnable  <= 1'b1;
        cyc(3'h5, 6'h30);
        ticks(6);
        @(negedge clk);
        check("read held for grant", 9'h003, {7'h00, memReadN, memReadLine});
        @(posedge clk);
        arbiterBusGrantN <= 1'b0;
        n = 0;
        while (memReadN !== 1'b0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("grant delay", 9'h001, {8'h00, n > 6 && n < 14});
        @(posedge clk);
        arbiterBusGrantN <= 1'b1;
        @(negedge clk);
        check("released", 9'h001, {6'h00, ioCmdDriveEn, memCmdDriveEn, memReadLine});
        ticks(40);
        busModeStrap <= 1'b1;
        doReset();
        run(3'h1, 9'h17c, 2'h2, "io mode read");
        run(3'h5, 9'h1fe, 2'h3, "io mode memory");
        endSim();
    end
endmodule // testbench
`default_nettype wire
